/* lsm_cfg.svh */
/*
  Offsets, field positions, reset values and timing counts of the
  supply monitor control block.
  Assumes a 40 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
`ifndef LSM_CFG_SVH
`define LSM_CFG_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define LSM_OFF_CTRL 8'h00
`define LSM_OFF_STATE 8'h04
`define LSM_OFF_IRQ_STATUS 8'h08
`define LSM_OFF_IRQ_CLEAR 8'h0C
`define LSM_OFF_IRQ_ENABLE 8'h10

// ************************************************************
// control register fields and reset values
// ************************************************************
`define LSM_CTRL_FLAG_BIT 0
`define LSM_CTRL_SRC_BIT 2
`define LSM_CTRL_THR_LSB 3
`define LSM_CTRL_THR_MSB 7
`define LSM_THR_RESET 5'h00
`define LSM_SRC_RESET 1'b0

// ************************************************************
// interrupt bits, responses and timing
// ************************************************************
`define LSM_IRQ_SETTLED 0
`define LSM_IRQ_REFUSED 1
`define LSM_IRQ_RESET 2'h0
`define LSM_RESP_OKAY 2'h0
`define LSM_RESP_SLVERR 2'h2
`define LSM_CLK_PERIOD_NS 25
`define LSM_SETTLE_TIME_NS 10000
`define LSM_SETTLE_CYCLES \
  ((`LSM_SETTLE_TIME_NS + `LSM_CLK_PERIOD_NS - 1) / `LSM_CLK_PERIOD_NS)

`endif

/* lsm_pkg.sv */
/*
  State types of the supply monitor control block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package lsm_pkg;

  // monitor power sequence, one-hot
  typedef enum logic [2:0] {
    MON_OFF = 3'b001,
    MON_SETTLE = 3'b010,
    MON_ON = 3'b100
  } mon_state_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } sync_state_t;

  typedef struct packed {
    logic loaded;
    logic value;
    logic refused;
  } fuse_state_t;

  typedef struct packed {
    mon_state_t mon;
    logic [8:0] settle_cnt;
    logic power_on;
    logic flag;
    logic [4:0] threshold;
    logic source;
    logic [1:0] irq_status;
    logic [1:0] irq_enable;
    logic irq;
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } ctl_state_t;

endpackage : lsm_pkg

/* lsm_sync.sv */
/*
  Three-flop synchroniser with agreement filter for one level.
  Assumes the input is asynchronous to sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module lsm_sync (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic async_in,
  output logic sync_out
);

  lsm_pkg::sync_state_t state_reg;
  lsm_pkg::sync_state_t state_next;

  // s1 feeds only s2; q moves once s2 and s3 agree
  always_comb begin
    state_next = state_reg;
    state_next.s1 = async_in;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    if (state_reg.s2 == state_reg.s3) begin
      state_next.q = state_reg.s3;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_out = state_reg.q;

  a_sync_filter: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_reg.s2 != state_reg.s3) |=> $stable(state_reg.q))
    else $error("sync output moved without agreement");

endmodule : lsm_sync

`default_nettype wire

/* lsm_fuse.sv */
/*
  One-time monitor enable bit of the initialization register.
  Assumes the stored value arrives on a strap level and that the
  programming port is on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module lsm_fuse (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic fuse_strap,
  input wire logic programming_mode,
  input wire logic global_write_protect,
  input wire logic fuse_write,
  input wire logic fuse_write_value,
  output logic fuse_value,
  output logic fuse_refused
);

  lsm_pkg::fuse_state_t state_reg;
  lsm_pkg::fuse_state_t state_next;

  // strap caught once after release; later changes only by programming
  always_comb begin
    state_next = state_reg;
    state_next.refused = 1'b0;
    if (!state_reg.loaded) begin
      state_next.loaded = 1'b1;
      state_next.value = fuse_strap;
    end else if (fuse_write && programming_mode) begin
      if (fuse_write_value) begin
        state_next.value = 1'b1;
      end else if (!global_write_protect) begin
        state_next.value = 1'b0;
      end else begin
        state_next.refused = 1'b1;
      end
    end else if (fuse_write) begin
      // software outside programming mode never changes the bit
      state_next.refused = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign fuse_value = state_reg.value;
  assign fuse_refused = state_reg.refused;

  a_clear_guard: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ($fell(state_reg.value) && $past(state_reg.loaded)) |->
      $past(programming_mode && !global_write_protect))
    else $error("enable cleared outside unprotected programming");

  a_set_guard: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ($rose(state_reg.value) && $past(state_reg.loaded)) |->
      $past(programming_mode))
    else $error("enable set outside programming mode");

endmodule : lsm_fuse

`default_nettype wire

/* low_supply_monitor_control.sv */
/*
  Control and status logic around the supply comparator: threshold
  and source selection, low-supply flag, power sequencing, interrupt
  status and an AXI4-Lite register slave.
  Assumes the analog comparator, reference and sense mux sit outside,
  the comparator output is asynchronous, and low_power_mode,
  programming_mode and the programming port are on sys_clk.
*/
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "lsm_cfg.svh"

module low_supply_monitor_control (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic comparator_below_async,
  input wire logic low_power_mode,
  input wire logic programming_mode,
  input wire logic global_write_protect,
  input wire logic fuse_strap,
  input wire logic prog_fuse_write,
  input wire logic prog_fuse_value,
  output logic monitor_enable_fuse,
  output logic monitor_power_on,
  output logic [4:0] threshold_select,
  output logic monitor_source_select,
  output logic irq
);

  // ************************************************************
  // state and helpers
  // ************************************************************
  lsm_pkg::ctl_state_t state_reg;
  lsm_pkg::ctl_state_t state_next;
  logic cmp_below;
  logic fuse_refused;
  logic monitor_wanted;
  logic wr_fire;
  logic rd_fire;
  logic settle_done;
  logic [7:0] wr_word;
  logic [7:0] rd_word;
  logic [1:0] irq_events;

  localparam logic [8:0] SETTLE_LAST = 9'(`LSM_SETTLE_CYCLES - 1);

  // ************************************************************
  // submodules
  // ************************************************************
  lsm_sync cmp_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in(comparator_below_async),
    .sync_out(cmp_below)
  );

  lsm_fuse enable_fuse (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .fuse_strap(fuse_strap),
    .programming_mode(programming_mode),
    .global_write_protect(global_write_protect),
    .fuse_write(prog_fuse_write),
    .fuse_write_value(prog_fuse_value),
    .fuse_value(monitor_enable_fuse),
    .fuse_refused(fuse_refused)
  );

  // handshake terms of the current state
  assign wr_fire = state_reg.aw_got && state_reg.w_got && !state_reg.bvalid;
  assign rd_fire = arvalid && state_reg.arready;
  assign wr_word = {state_reg.aw_addr[7:2], 2'h0};
  assign rd_word = {araddr[7:2], 2'h0};
  // low power wins over the fuse: circuit never runs in halt or idle
  assign monitor_wanted = monitor_enable_fuse && !low_power_mode;
  assign settle_done = (state_reg.mon == lsm_pkg::MON_SETTLE) &&
                       monitor_wanted && (state_reg.settle_cnt == SETTLE_LAST);
  // flag changes are deliberately not an interrupt source
  assign irq_events = {fuse_refused, settle_done};

  // ************************************************************
  // next-state logic
  // ************************************************************
  always_comb begin
    state_next = state_reg;
    state_next.power_on = monitor_wanted;

    // power sequence: off, settle for the stabilising time, on
    case (state_reg.mon)
      lsm_pkg::MON_OFF: begin
        state_next.settle_cnt = 9'h000;
        if (monitor_wanted) begin
          state_next.mon = lsm_pkg::MON_SETTLE;
        end
      end
      lsm_pkg::MON_SETTLE: begin
        if (!monitor_wanted) begin
          state_next.mon = lsm_pkg::MON_OFF;
        end else if (settle_done) begin
          state_next.mon = lsm_pkg::MON_ON;
        end else begin
          state_next.settle_cnt = state_reg.settle_cnt + 9'h001;
        end
      end
      lsm_pkg::MON_ON: begin
        // flag follows the comparator: set below, clear once above
        state_next.flag = cmp_below;
        if (!monitor_wanted) begin
          state_next.mon = lsm_pkg::MON_OFF;
        end
      end
      default: begin
        state_next.mon = lsm_pkg::MON_OFF;
      end
    endcase

    // write address and data channels taken in either order
    if (awvalid && state_reg.awready) begin
      state_next.awready = 1'b0;
      state_next.aw_got = 1'b1;
      state_next.aw_addr = awaddr;
    end
    if (wvalid && state_reg.wready) begin
      state_next.wready = 1'b0;
      state_next.w_got = 1'b1;
      state_next.w_data = wdata[7:0];
      state_next.w_lane0 = wstrb[0];
    end

    // sticky status: a new event beats a clear in the same cycle
    state_next.irq_status = state_reg.irq_status | irq_events;

    if (wr_fire) begin
      state_next.aw_got = 1'b0;
      state_next.w_got = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = `LSM_RESP_OKAY;
      case (wr_word)
        `LSM_OFF_CTRL: begin
          // flag bit is ignored on write; threshold may move live
          if (state_reg.w_lane0) begin
            state_next.threshold =
              state_reg.w_data[`LSM_CTRL_THR_MSB:`LSM_CTRL_THR_LSB];
            state_next.source = state_reg.w_data[`LSM_CTRL_SRC_BIT];
          end
        end
        `LSM_OFF_STATE: begin
          state_next.bresp = `LSM_RESP_OKAY;
        end
        `LSM_OFF_IRQ_STATUS: begin
          state_next.bresp = `LSM_RESP_OKAY;
        end
        `LSM_OFF_IRQ_CLEAR: begin
          if (state_reg.w_lane0) begin
            state_next.irq_status =
              (state_reg.irq_status & ~state_reg.w_data[1:0]) | irq_events;
          end
        end
        `LSM_OFF_IRQ_ENABLE: begin
          if (state_reg.w_lane0) begin
            state_next.irq_enable = state_reg.w_data[1:0];
          end
        end
        default: begin
          state_next.bresp = `LSM_RESP_SLVERR;
        end
      endcase
    end
    if (state_reg.bvalid && bready) begin
      state_next.bvalid = 1'b0;
      state_next.awready = 1'b1;
      state_next.wready = 1'b1;
    end

    // read channel: one read under way at a time
    if (rd_fire) begin
      state_next.arready = 1'b0;
      state_next.rvalid = 1'b1;
      state_next.rresp = `LSM_RESP_OKAY;
      state_next.rdata = 32'h0000_0000;
      case (rd_word)
        `LSM_OFF_CTRL: begin
          // bit 1 unused reads zero
          state_next.rdata[`LSM_CTRL_THR_MSB:`LSM_CTRL_THR_LSB] =
            state_reg.threshold;
          state_next.rdata[`LSM_CTRL_SRC_BIT] = state_reg.source;
          state_next.rdata[`LSM_CTRL_FLAG_BIT] = state_reg.flag;
        end
        `LSM_OFF_STATE: begin
          state_next.rdata[2:0] = {state_reg.mon == lsm_pkg::MON_ON,
                                   state_reg.power_on, monitor_enable_fuse};
        end
        `LSM_OFF_IRQ_STATUS: begin
          state_next.rdata[1:0] = state_reg.irq_status;
        end
        `LSM_OFF_IRQ_CLEAR: begin
          state_next.rdata = 32'h0000_0000;
        end
        `LSM_OFF_IRQ_ENABLE: begin
          state_next.rdata[1:0] = state_reg.irq_enable;
        end
        default: begin
          state_next.rresp = `LSM_RESP_SLVERR;
        end
      endcase
    end
    if (state_reg.rvalid && rready) begin
      state_next.rvalid = 1'b0;
      state_next.arready = 1'b1;
    end

    // level interrupt from enabled sticky bits
    state_next.irq = |(state_next.irq_status & state_reg.irq_enable);
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
      state_reg.mon <= lsm_pkg::MON_OFF;
      state_reg.threshold <= `LSM_THR_RESET;
      state_reg.source <= `LSM_SRC_RESET;
      state_reg.irq_status <= `LSM_IRQ_RESET;
      state_reg.irq_enable <= `LSM_IRQ_RESET;
      state_reg.awready <= 1'b1;
      state_reg.wready <= 1'b1;
      state_reg.arready <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ************************************************************
  // outputs, all straight from flops
  // ************************************************************
  assign awready = state_reg.awready;
  assign wready = state_reg.wready;
  assign bvalid = state_reg.bvalid;
  assign bresp = state_reg.bresp;
  assign arready = state_reg.arready;
  assign rvalid = state_reg.rvalid;
  assign rdata = state_reg.rdata;
  assign rresp = state_reg.rresp;
  assign monitor_power_on = state_reg.power_on;
  // code drives the reference ladder as is: zero is the lowest step
  assign threshold_select = state_reg.threshold;
  assign monitor_source_select = state_reg.source;
  assign irq = state_reg.irq;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_ctrl_write;
    wr_fire && (wr_word == `LSM_OFF_CTRL) && state_reg.w_lane0;
  endsequence

  sequence s_ctrl_read;
    rd_fire && (rd_word == `LSM_OFF_CTRL);
  endsequence

  sequence s_settle_entry;
    (state_reg.mon == lsm_pkg::MON_OFF) ##1
      (state_reg.mon == lsm_pkg::MON_SETTLE);
  endsequence

  a_flag_sets: assert property (
    (state_reg.mon == lsm_pkg::MON_ON) && cmp_below && monitor_wanted
      |=> state_reg.flag)
    else $error("flag not set while below threshold");

  a_flag_holds: assert property (
    $fell(state_reg.flag) |->
      $past(!cmp_below && state_reg.mon == lsm_pkg::MON_ON))
    else $error("flag cleared without voltage above threshold");

  a_ctrl_read: assert property (
    s_ctrl_read |=> state_reg.rvalid &&
      (state_reg.rdata[1:0] == {1'b0, $past(state_reg.flag)}) &&
      (state_reg.rdata[7:3] == $past(state_reg.threshold)))
    else $error("control read does not show flag and fields");

  a_flag_nowrite: assert property (
    (s_ctrl_write and (state_reg.mon != lsm_pkg::MON_ON)) |=>
      $stable(state_reg.flag))
    else $error("write changed the flag");

  a_thresh_write: assert property (
    s_ctrl_write |=> (threshold_select == $past(state_reg.w_data[7:3])))
    else $error("threshold field not taken");

  a_source_write: assert property (
    s_ctrl_write |=> (monitor_source_select == $past(state_reg.w_data[2])))
    else $error("source select not taken");

  a_no_flag_irq: assert property (
    $rose(state_reg.irq_status[`LSM_IRQ_SETTLED]) |->
      $past(state_reg.mon == lsm_pkg::MON_SETTLE))
    else $error("status set by something other than settling");

  a_fuse_gate: assert property (
    !monitor_enable_fuse |=> !monitor_power_on)
    else $error("monitor powered without enable fuse");

  a_low_power_off: assert property (
    low_power_mode |=> !monitor_power_on &&
      (state_reg.mon == lsm_pkg::MON_OFF))
    else $error("monitor left on in low power");

  a_settle_time: assert property (
    s_settle_entry |-> (state_reg.mon != lsm_pkg::MON_ON)[*8])
    else $error("monitor declared settled too early");

  a_settle_count: assert property (
    $rose(state_reg.mon == lsm_pkg::MON_ON) |->
      $past(state_reg.settle_cnt) == SETTLE_LAST)
    else $error("settle count wrong");

endmodule : low_supply_monitor_control

`default_nettype wire

/* tb_low_supply_monitor_control.sv */
/*
  Self-checking bench of the supply monitor control block: register
  bus, threshold and source fields, flag, power sequence, enable bit.
  Assumes lsm_cfg.svh and the design files are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lsm_cfg.svh"

`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin \
  miscompares++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end

module tb_low_supply_monitor_control;
  // ************************************************************
  // signals and reference model state
  // ************************************************************
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic comparator_below_async = 1'b0, low_power_mode = 1'b0;
  logic programming_mode = 1'b0, global_write_protect = 1'b0;
  logic fuse_strap = 1'b1, prog_fuse_write = 1'b0, prog_fuse_value = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic monitor_enable_fuse, monitor_power_on, monitor_source_select;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rd, d;
  logic [4:0] threshold_select, exp_thr = 5'h00;
  logic exp_src = 1'b0, exp_flag = 1'b0, exp_fuse = 1'b1, ok;
  logic [2:0] rows [5] = '{3'b000, 3'b110, 3'b100, 3'b111, 3'b001};
  int miscompares = 0;
  int n_checks = 0;

  // 40 MHz system clock
  always #12.5 sys_clk = ~sys_clk;

  low_supply_monitor_control i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .comparator_below_async(comparator_below_async),
    .low_power_mode(low_power_mode), .programming_mode(programming_mode),
    .global_write_protect(global_write_protect), .fuse_strap(fuse_strap),
    .prog_fuse_write(prog_fuse_write), .prog_fuse_value(prog_fuse_value),
    .monitor_enable_fuse(monitor_enable_fuse),
    .monitor_power_on(monitor_power_on),
    .threshold_select(threshold_select),
    .monitor_source_select(monitor_source_select), .irq(irq)
  );

  // ************************************************************
  // bus tasks
  // ************************************************************
  // address and data offered together, each dropped once taken
  task automatic bus_write(input logic [7:0] a, input logic [31:0] v,
                           output logic [1:0] r);
    int i;
    @(posedge sys_clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= v;
    bready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (i == 40) `CHK(1'b0, 1'b1)
  endtask : bus_write

  task automatic bus_read(input logic [7:0] a, output logic [31:0] v,
                          output logic [1:0] r);
    int i;
    @(posedge sys_clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        v = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (i == 40) `CHK(1'b0, 1'b1)
  endtask : bus_read

  // control byte against the model
  task automatic check_ctrl();
    bus_read(`LSM_OFF_CTRL, rd, rsp);
    `CHK(rd, {24'h0, exp_thr, exp_src, 1'b0, exp_flag})
  endtask : check_ctrl

  // flag passes a synchroniser, so poll with a bound
  task automatic wait_flag(input logic want);
    for (int i = 0; i < 30; i++) begin
      bus_read(`LSM_OFF_CTRL, rd, rsp);
      if (rd[0] === want) break;
    end
    exp_flag = want;
    check_ctrl();
  endtask : wait_flag

  // settle lasts 400 cycles, each poll takes about three
  task automatic wait_settled();
    for (int i = 0; i < 300; i++) begin
      bus_read(`LSM_OFF_IRQ_STATUS, rd, rsp);
      if (rd[0] === 1'b1) break;
    end
    `CHK(rd[0], 1'b1)
  endtask : wait_settled

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  // ************************************************************
  // tests
  // ************************************************************
  // watchdog: whole run needs well under 8000 cycles
  initial begin
    #(25 * 20000);
    miscompares++;
    $display("unexpected at %0t: watchdog expired", $time);
    summarize();
  end

  initial begin
    void'($urandom(50356));
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    check_ctrl();
    bus_read(8'h20, rd, rsp);
    `CHK({rsp, rd}, {2'h2, 32'h0})
    bus_write(8'h20, 32'hFF, rsp);
    `CHK(rsp, 2'h2)
    $display("test registers done");
    // every threshold code, random source bit and junk in the flag bit
    for (int c = 0; c < 32; c++) begin
      d = $urandom();
      d[7:3] = c[4:0];
      bus_write(`LSM_OFF_CTRL, d, rsp);
      exp_thr = c[4:0];
      exp_src = d[2];
      `CHK(threshold_select, exp_thr)
      `CHK(monitor_source_select, exp_src)
      check_ctrl();
    end
    $display("test thresholds done");
    `CHK(monitor_enable_fuse, 1'b1)
    `CHK(monitor_power_on, 1'b1)
    wait_settled();
    // fuse set, powered, settled
    bus_read(`LSM_OFF_STATE, rd, rsp);
    `CHK(rd, 32'h0000_0007)
    `CHK(irq, 1'b0)
    bus_write(`LSM_OFF_IRQ_ENABLE, 32'h1, rsp);
    repeat (2) @(posedge sys_clk);
    `CHK(irq, 1'b1)
    bus_write(`LSM_OFF_IRQ_CLEAR, 32'h1, rsp);
    repeat (2) @(posedge sys_clk);
    `CHK(irq, 1'b0)
    $display("test power and interrupt done");
    comparator_below_async <= 1'b1;
    wait_flag(1'b1);
    bus_write(`LSM_OFF_CTRL, 32'h0, rsp);
    exp_thr = 5'h00;
    exp_src = 1'b0;
    check_ctrl();
    bus_read(`LSM_OFF_IRQ_STATUS, rd, rsp);
    `CHK({rd[1:0], irq}, 3'h0)
    comparator_below_async <= 1'b0;
    wait_flag(1'b0);
    $display("test flag done");
    low_power_mode <= 1'b1;
    comparator_below_async <= 1'b1;
    repeat (3) @(posedge sys_clk);
    `CHK(monitor_power_on, 1'b0)
    repeat (20) @(posedge sys_clk);
    check_ctrl();
    // only the fuse bit stands while the circuit is off
    bus_read(`LSM_OFF_STATE, rd, rsp);
    `CHK(rd, 32'h0000_0001)
    low_power_mode <= 1'b0;
    wait_settled();
    wait_flag(1'b1);
    comparator_below_async <= 1'b0;
    wait_flag(1'b0);
    bus_write(`LSM_OFF_IRQ_CLEAR, 32'h3, rsp);
    $display("test low power done");
    // enable bit: {programming, protect, value} per row
    foreach (rows[k]) begin
      @(posedge sys_clk);
      programming_mode <= rows[k][2];
      global_write_protect <= rows[k][1];
      prog_fuse_value <= rows[k][0];
      prog_fuse_write <= 1'b1;
      @(posedge sys_clk);
      prog_fuse_write <= 1'b0;
      repeat (3) @(posedge sys_clk);
      ok = rows[k][2] && (rows[k][0] || !rows[k][1]);
      if (ok) exp_fuse = rows[k][0];
      `CHK(monitor_enable_fuse, exp_fuse)
      bus_read(`LSM_OFF_IRQ_STATUS, rd, rsp);
      `CHK(rd[1], !ok)
      if (!exp_fuse) `CHK(monitor_power_on, 1'b0)
      bus_write(`LSM_OFF_IRQ_CLEAR, 32'h2, rsp);
    end
    $display("test enable bit done");
    summarize();
  end
endmodule : tb_low_supply_monitor_control
`default_nettype wire
